/* File: core/hims_map.svh */
// Offsets, field positions and reset values of the microframe status block
//
// Operation
// - A microframe's 12-bit receive count is written only when its active bit is 1 and the frame matched.
// - Counts of microframes 0 and 1 sit at bits 43:32 and 55:44, microframe 2 splits over 63:56 and 3:0 of the next pair.
// - Eight 3-bit result fields pack upward from bits 10:8 for microframe 0 to bits 31:29 for microframe 7.
// - A result field is written only after that microframe's transaction has completed on the bus.
// - Result bit 0 flags a transaction error for IN and OUT.
// - Result bit 1 flags babble and is only set for IN tokens.
// - Result bit 2 flags an underrun and is only set for OUT tokens.
// - Software only sets active mask bits, and the controller clears each one once its microframe is processed.
// - When frame field bits 7:3 equal the bus frame number, a transaction is issued only in microframes whose bit is 1.
// - All eight bits set means every microframe is served, only even bits means microframes 0, 2, 4 and 6 only.
`ifndef HIMS_MAP_SVH
`define HIMS_MAP_SVH

`define HIMS_ADDR_W        5
`define HIMS_DATA_W        32
`define HIMS_UFRAMES       8
`define HIMS_COUNT_W       12
`define HIMS_RES_W         3
`define HIMS_IDX_W         3
`define HIMS_FRAME_W       5

`define HIMS_OFS_DW4       5'h00
`define HIMS_OFS_DW5       5'h04
`define HIMS_OFS_DW6       5'h08
`define HIMS_OFS_DW7       5'h0C
`define HIMS_OFS_FRAME     5'h10
`define HIMS_OFS_INT_STAT  5'h14
`define HIMS_OFS_INT_MASK  5'h18

`define HIMS_MASK_LSB      0
`define HIMS_MASK_MSB      7
`define HIMS_RES_LSB       8
`define HIMS_RES_MSB       31
`define HIMS_FRAME_NUM_LSB 3
`define HIMS_FRAME_NUM_MSB 7
`define HIMS_FRAME_FLD_W   8

`define HIMS_RES_ERR_BIT   0
`define HIMS_RES_BABL_BIT  1
`define HIMS_RES_UNDR_BIT  2

`define HIMS_INT_W         3
`define HIMS_INT_DONE_BIT  0
`define HIMS_INT_ERR_BIT   1
`define HIMS_INT_IDLE_BIT  2

`define HIMS_MASK_RST      8'h00
`define HIMS_FRAME_RST     8'h00
`define HIMS_INT_RST       3'h0
`define HIMS_COUNT_RST     12'h000
`define HIMS_RESULT_RST    3'h0
`define HIMS_WORD_ZERO     32'h00000000

`endif

/* File: core/hims_pkg.sv */
// Types shared by the microframe status block
package hims_pkg;

	typedef enum logic [0:0] {
		HIMS_ST_IDLE = 1'b0,
		HIMS_ST_WAIT = 1'b1
	} hims_state_type;

	typedef logic [11:0] hims_count_type;
	typedef logic [2:0]  hims_result_type;

endpackage : hims_pkg

/* File: core/hims_uframe_slot.sv */
// One microframe's receive count and result holder
`timescale 1ns/1ps
`include "hims_map.svh"

module hims_uframe_slot
	import hims_pkg::*;
#(
	parameter int COUNT_W = `HIMS_COUNT_W
) (
	input  wire logic               clk_in,     // Core clock
	input  wire logic               resetn_in,  // Sync reset, active low
	input  wire logic               load_in,    // Transaction of this slot done
	input  wire logic [COUNT_W-1:0] count_in,   // Bytes received
	input  wire logic               token_in_in,// 1 for IN, 0 for OUT
	input  wire logic               err_in,     // Transaction error
	input  wire logic               babble_in,  // Babble seen
	input  wire logic               underrun_in,// Underrun seen
	output logic      [COUNT_W-1:0] count_out,  // Stored count
	output logic      [2:0]         result_out  // Stored result
);

	generate
		if (COUNT_W < 1) begin : g_bad_width
			$error("hims_uframe_slot: COUNT_W must be at least 1");
		end
	endgenerate

	logic [COUNT_W-1:0] count_ff;
	logic [2:0]         result_ff;
	wire  [2:0]         nxt_result;

	assign nxt_result[`HIMS_RES_ERR_BIT]  = err_in;
	assign nxt_result[`HIMS_RES_BABL_BIT] = babble_in & token_in_in;
	assign nxt_result[`HIMS_RES_UNDR_BIT] = underrun_in & ~token_in_in;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			count_ff  <= '0;
			result_ff <= `HIMS_RESULT_RST;
		end else if (load_in) begin
			count_ff  <= count_in;
			result_ff <= nxt_result;
		end
	end

	assign count_out  = count_ff;
	assign result_out = result_ff;

endmodule : hims_uframe_slot

/* File: core/hims_uframe_status.sv */
// Per-microframe status of a high-speed isochronous transfer descriptor
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "hims_map.svh"

module hims_uframe_status
	import hims_pkg::*;
#(
	parameter int UFRAMES = `HIMS_UFRAMES,
	parameter int COUNT_W = `HIMS_COUNT_W
) (
	input  wire logic                       clk_in,          // Core clock, 40 MHz
	input  wire logic                       resetn_in,       // Sync reset, active low
	input  wire logic [`HIMS_ADDR_W-1:0]    reg_addr_in,     // Register byte address
	input  wire logic [`HIMS_DATA_W-1:0]    reg_wdata_in,    // Register write data
	input  wire logic                       reg_wr_in,       // Write strobe
	input  wire logic                       reg_rd_in,       // Read strobe
	output logic      [`HIMS_DATA_W-1:0]    reg_rdata_out,   // Read data, cycle after strobe
	input  wire logic                       usof_in,         // Microframe start pulse
	input  wire logic [`HIMS_FRAME_W-1:0]   bus_frame_in,    // Current bus frame number
	input  wire logic [`HIMS_IDX_W-1:0]     usof_index_in,   // Microframe index in frame
	input  wire logic                       token_in_in,     // 1 for IN, 0 for OUT
	input  wire logic                       xact_done_in,    // Transaction finished pulse
	input  wire logic [COUNT_W-1:0]         xact_count_in,   // Bytes received
	input  wire logic                       xact_err_in,     // Transaction error
	input  wire logic                       xact_babble_in,  // Babble seen
	input  wire logic                       xact_underrun_in,// Underrun seen
	output logic                            xact_issue_out,  // Issue transaction pulse
	output logic      [`HIMS_IDX_W-1:0]     xact_uframe_out, // Microframe being served
	output logic                            irq_out          // Level interrupt
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	////////////////////////////////////////////////////////////////////////////////

	generate
		if (UFRAMES != `HIMS_UFRAMES) begin : g_bad_uframes
			$error("hims_uframe_status: UFRAMES must be 8");
		end
		if (COUNT_W != `HIMS_COUNT_W) begin : g_bad_count
			$error("hims_uframe_status: COUNT_W must be 12 for the packed layout");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// State
	////////////////////////////////////////////////////////////////////////////////

	hims_state_type                    state_ff;
	hims_state_type                    nxt_state;
	logic [UFRAMES-1:0]                mask_ff;
	logic [UFRAMES-1:0]                nxt_mask;
	logic [`HIMS_FRAME_FLD_W-1:0]      frame_ff;
	logic [`HIMS_IDX_W-1:0]            cur_uf_ff;
	logic [`HIMS_IDX_W-1:0]            nxt_cur_uf;
	logic                              issue_ff;
	logic [`HIMS_INT_W-1:0]            int_stat_ff;
	logic [`HIMS_INT_W-1:0]            nxt_int_stat;
	logic [`HIMS_INT_W-1:0]            int_mask_ff;
	logic                              irq_ff;
	logic [`HIMS_DATA_W-1:0]           rdata_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Register decode
	////////////////////////////////////////////////////////////////////////////////

	wire sel_dw4      = (reg_addr_in == `HIMS_OFS_DW4);
	wire sel_dw5      = (reg_addr_in == `HIMS_OFS_DW5);
	wire sel_dw6      = (reg_addr_in == `HIMS_OFS_DW6);
	wire sel_dw7      = (reg_addr_in == `HIMS_OFS_DW7);
	wire sel_frame    = (reg_addr_in == `HIMS_OFS_FRAME);
	wire sel_int_stat = (reg_addr_in == `HIMS_OFS_INT_STAT);
	wire sel_int_mask = (reg_addr_in == `HIMS_OFS_INT_MASK);

	wire wr_dw4      = reg_wr_in & sel_dw4;
	wire wr_frame    = reg_wr_in & sel_frame;
	wire wr_int_stat = reg_wr_in & sel_int_stat;
	wire wr_int_mask = reg_wr_in & sel_int_mask;

	wire [UFRAMES-1:0] sw_set_mask = wr_dw4 ? reg_wdata_in[`HIMS_MASK_MSB:`HIMS_MASK_LSB] : '0;

	////////////////////////////////////////////////////////////////////////////////
	// Microframe scheduling
	////////////////////////////////////////////////////////////////////////////////

	wire [`HIMS_FRAME_W-1:0] target_frame = frame_ff[`HIMS_FRAME_NUM_MSB:`HIMS_FRAME_NUM_LSB];
	wire                     frame_match  = (target_frame == bus_frame_in);
	wire                     start_xact   = usof_in & frame_match & mask_ff[usof_index_in];
	wire                     finish_xact  = (state_ff == HIMS_ST_WAIT) & xact_done_in & ~usof_in;

	wire [UFRAMES-1:0] uf_onehot = UFRAMES'(1) << cur_uf_ff;
	wire [UFRAMES-1:0] hw_clr_mask = finish_xact ? uf_onehot : '0;

	// Error interrupt follows the stored result, not the raw flags
	wire xact_errored = xact_err_in |
		(xact_babble_in & token_in_in) |
		(xact_underrun_in & ~token_in_in);

	// A new microframe start abandons a transaction that never finished
	always_comb begin
		nxt_state  = state_ff;
		nxt_cur_uf = cur_uf_ff;
		case (state_ff)
			HIMS_ST_IDLE: begin
				if (start_xact) begin
					nxt_state  = HIMS_ST_WAIT;
					nxt_cur_uf = usof_index_in;
				end
			end
			HIMS_ST_WAIT: begin
				if (start_xact) begin
					nxt_cur_uf = usof_index_in;
				end else if (usof_in || xact_done_in) begin
					nxt_state = HIMS_ST_IDLE;
				end
			end
			default: begin
				nxt_state = HIMS_ST_IDLE;
			end
		endcase
	end

	assign nxt_mask = (mask_ff & ~hw_clr_mask) | sw_set_mask;

	// Issue is a one-cycle pulse, the index stays for the far side
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_ff  <= HIMS_ST_IDLE;
			cur_uf_ff <= '0;
			mask_ff   <= `HIMS_MASK_RST;
			issue_ff  <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			cur_uf_ff <= nxt_cur_uf;
			mask_ff   <= nxt_mask;
			issue_ff  <= start_xact;
		end
	end

	// Frame field kept whole, only its upper bits are compared
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			frame_ff <= `HIMS_FRAME_RST;
		end else if (wr_frame) begin
			frame_ff <= reg_wdata_in[`HIMS_FRAME_FLD_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-microframe count and result storage
	////////////////////////////////////////////////////////////////////////////////

	// One holder per microframe, moved only by its own completion
	logic [UFRAMES*COUNT_W-1:0]     counts_flat;
	logic [UFRAMES*`HIMS_RES_W-1:0] results_flat;

	genvar gi;
	generate
		for (gi = 0; gi < UFRAMES; gi++) begin : g_slot
			wire slot_load = finish_xact & uf_onehot[gi];

			hims_uframe_slot #(
				.COUNT_W (COUNT_W)
			) u_slot (
				.clk_in      (clk_in),
				.resetn_in   (resetn_in),
				.load_in     (slot_load),
				.count_in    (xact_count_in),
				.token_in_in (token_in_in),
				.err_in      (xact_err_in),
				.babble_in   (xact_babble_in),
				.underrun_in (xact_underrun_in),
				.count_out   (counts_flat[gi*COUNT_W +: COUNT_W]),
				.result_out  (results_flat[gi*`HIMS_RES_W +: `HIMS_RES_W])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Descriptor word packing
	////////////////////////////////////////////////////////////////////////////////

	// Named fields, so the packing below reads like the descriptor layout
	wire [COUNT_W-1:0]     uframe0_rx_count       = counts_flat[0*COUNT_W +: COUNT_W];
	wire [COUNT_W-1:0]     uframe1_rx_count       = counts_flat[1*COUNT_W +: COUNT_W];
	wire [COUNT_W-1:0]     uframe2_rx_count       = counts_flat[2*COUNT_W +: COUNT_W];
	wire [COUNT_W-1:0]     uframe3_rx_count       = counts_flat[3*COUNT_W +: COUNT_W];
	wire [COUNT_W-1:0]     uframe4_rx_count       = counts_flat[4*COUNT_W +: COUNT_W];
	wire [COUNT_W-1:0]     uframe5_rx_count       = counts_flat[5*COUNT_W +: COUNT_W];
	wire [COUNT_W-1:0]     uframe6_rx_count       = counts_flat[6*COUNT_W +: COUNT_W];
	wire [COUNT_W-1:0]     uframe7_rx_count       = counts_flat[7*COUNT_W +: COUNT_W];
	wire [`HIMS_RES_W-1:0] uframe0_result         = results_flat[0*`HIMS_RES_W +: `HIMS_RES_W];
	wire [`HIMS_RES_W-1:0] uframe1_result         = results_flat[1*`HIMS_RES_W +: `HIMS_RES_W];
	wire [`HIMS_RES_W-1:0] uframe2_result         = results_flat[2*`HIMS_RES_W +: `HIMS_RES_W];
	wire [`HIMS_RES_W-1:0] uframe3_result         = results_flat[3*`HIMS_RES_W +: `HIMS_RES_W];
	wire [`HIMS_RES_W-1:0] uframe4_result         = results_flat[4*`HIMS_RES_W +: `HIMS_RES_W];
	wire [`HIMS_RES_W-1:0] uframe5_result         = results_flat[5*`HIMS_RES_W +: `HIMS_RES_W];
	wire [`HIMS_RES_W-1:0] uframe6_result         = results_flat[6*`HIMS_RES_W +: `HIMS_RES_W];
	wire [`HIMS_RES_W-1:0] uframe7_result         = results_flat[7*`HIMS_RES_W +: `HIMS_RES_W];
	wire [UFRAMES-1:0]     microframe_active_mask = mask_ff;

	wire [`HIMS_DATA_W-1:0] dw4_word = {
		uframe7_result,
		uframe6_result,
		uframe5_result,
		uframe4_result,
		uframe3_result,
		uframe2_result,
		uframe1_result,
		uframe0_result,
		microframe_active_mask
	};
	// Counts 0, 1 and low of 2
	wire [`HIMS_DATA_W-1:0] dw5_word = {
		uframe2_rx_count[7:0],
		uframe1_rx_count,
		uframe0_rx_count
	};
	// High of 2 at bits 3:0
	wire [`HIMS_DATA_W-1:0] dw6_word = {
		uframe5_rx_count[3:0],
		uframe4_rx_count,
		uframe3_rx_count,
		uframe2_rx_count[11:8]
	};
	// High of 5, then 6 and 7
	wire [`HIMS_DATA_W-1:0] dw7_word = {
		uframe7_rx_count,
		uframe6_rx_count,
		uframe5_rx_count[11:4]
	};

	wire [`HIMS_DATA_W-1:0] frame_word    = {{(`HIMS_DATA_W-`HIMS_FRAME_FLD_W){1'b0}}, frame_ff};
	wire [`HIMS_DATA_W-1:0] int_stat_word = {{(`HIMS_DATA_W-`HIMS_INT_W){1'b0}}, int_stat_ff};
	wire [`HIMS_DATA_W-1:0] int_mask_word = {{(`HIMS_DATA_W-`HIMS_INT_W){1'b0}}, int_mask_ff};

	// Unmapped addresses read as zero
	wire [`HIMS_DATA_W-1:0] rd_word =
		({`HIMS_DATA_W{sel_dw4}}      & dw4_word)      |
		({`HIMS_DATA_W{sel_dw5}}      & dw5_word)      |
		({`HIMS_DATA_W{sel_dw6}}      & dw6_word)      |
		({`HIMS_DATA_W{sel_dw7}}      & dw7_word)      |
		({`HIMS_DATA_W{sel_frame}}    & frame_word)    |
		({`HIMS_DATA_W{sel_int_stat}} & int_stat_word) |
		({`HIMS_DATA_W{sel_int_mask}} & int_mask_word);

	// Data valid only in the cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rdata_ff <= `HIMS_WORD_ZERO;
		end else if (reg_rd_in) begin
			rdata_ff <= rd_word;
		end else begin
			rdata_ff <= `HIMS_WORD_ZERO;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts
	////////////////////////////////////////////////////////////////////////////////

	wire [`HIMS_INT_W-1:0] int_events;
	assign int_events[`HIMS_INT_DONE_BIT] = finish_xact;
	assign int_events[`HIMS_INT_ERR_BIT]  = finish_xact & xact_errored;
	// Whole schedule drained by hardware, not by a rearm
	assign int_events[`HIMS_INT_IDLE_BIT] = finish_xact & (mask_ff != '0) & (nxt_mask == '0);

	// Event set wins over a write-one clear
	wire [`HIMS_INT_W-1:0] int_clr = wr_int_stat ? reg_wdata_in[`HIMS_INT_W-1:0] : '0;
	assign nxt_int_stat = (int_stat_ff & ~int_clr) | int_events;

	// Pin lags status by one cycle so it stays a plain flop
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			int_stat_ff <= `HIMS_INT_RST;
			int_mask_ff <= `HIMS_INT_RST;
			irq_ff      <= 1'b0;
		end else begin
			int_stat_ff <= nxt_int_stat;
			if (wr_int_mask) begin
				int_mask_ff <= reg_wdata_in[`HIMS_INT_W-1:0];
			end
			irq_ff <= |(int_stat_ff & int_mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	////////////////////////////////////////////////////////////////////////////////

	assign reg_rdata_out   = rdata_ff;
	assign xact_issue_out  = issue_ff;
	assign xact_uframe_out = cur_uf_ff;
	assign irq_out         = irq_ff;

endmodule : hims_uframe_status

/* File: dv/hims_uframe_status_sva.sv */
// Port-level assertion checker for the microframe status block
`timescale 1ns/1ps
module hims_uframe_status_sva #(
	parameter int UFRAMES = 8,
	parameter int COUNT_W = 12
) (
	input wire logic               clk_in,           // Core clock
	input wire logic               resetn_in,        // Sync reset
	input wire logic [4:0]         reg_addr_in,      // Address
	input wire logic [31:0]        reg_wdata_in,     // Write data
	input wire logic               reg_wr_in,        // Write strobe
	input wire logic               reg_rd_in,        // Read strobe
	input wire logic [31:0]        reg_rdata_out,    // Read data
	input wire logic               usof_in,          // Microframe start
	input wire logic [4:0]         bus_frame_in,     // Bus frame
	input wire logic [2:0]         usof_index_in,    // Microframe index
	input wire logic               token_in_in,      // IN or OUT
	input wire logic               xact_done_in,     // Done pulse
	input wire logic [COUNT_W-1:0] xact_count_in,    // Byte count
	input wire logic               xact_err_in,      // Error flag
	input wire logic               xact_babble_in,   // Babble flag
	input wire logic               xact_underrun_in, // Underrun flag
	input wire logic               xact_issue_out,   // Issue pulse
	input wire logic [2:0]         xact_uframe_out,  // Served index
	input wire logic               irq_out           // Interrupt
);
	// Unmapped or misaligned read in flight
	logic rd_bad;
	assign rd_bad = reg_rd_in && ((reg_addr_in > 5'h18) || (reg_addr_in[1:0] != 2'h0));
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	a_issue_after_usof: assert property (xact_issue_out |-> $past(usof_in)) else $error("issue without start");
	a_issue_single: assert property (xact_issue_out |=> !xact_issue_out) else $error("issue pulse too long");
	a_uframe_index: assert property (xact_issue_out |-> xact_uframe_out == $past(usof_index_in))
		else $error("issued index wrong");
	a_uframe_hold: assert property (!$past(usof_in) |-> $stable(xact_uframe_out)) else $error("index moved");
	a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h00000000)
		else $error("read data outside slot");
	a_unmapped_zero: assert property ($past(rd_bad) |-> reg_rdata_out == 32'h00000000)
		else $error("unmapped read not zero");
	a_irq_rise_cause: assert property ($rose(irq_out) |-> $past(xact_done_in, 2) || $past(reg_wr_in, 2))
		else $error("interrupt rose without cause");
	a_irq_fall_cause: assert property ($fell(irq_out) |-> $past(reg_wr_in, 2))
		else $error("interrupt fell without write");
endmodule : hims_uframe_status_sva

/* File: dv/hims_iso_endpoint.sv */
// Far-side isochronous endpoint model answering issued transactions
`timescale 1ns/1ps
module hims_iso_endpoint (
	input  wire logic        clk_in,       // Core clock
	input  wire logic        issue_in,     // Transaction issued
	input  wire logic [3:0]  delay_in,     // Answer delay, cycles
	input  wire logic [11:0] count_in,     // Bytes to report
	input  wire logic [2:0]  flags_in,     // Underrun, babble, error
	output logic             done_out,     // Transaction finished
	output logic      [11:0] count_out,    // Bytes received
	output logic             err_out,      // Error flag
	output logic             babble_out,   // Babble flag
	output logic             underrun_out  // Underrun flag
);
	initial begin
		done_out = 1'b0;
		count_out = 12'h000;
		{underrun_out, babble_out, err_out} = 3'h0;
		forever begin
			@(posedge clk_in);
			if (issue_in) begin
				repeat (delay_in) @(posedge clk_in);
				done_out <= 1'b1;
				count_out <= count_in;
				{underrun_out, babble_out, err_out} <= flags_in;
				@(posedge clk_in);
				done_out <= 1'b0;
				// Released lines flip so a stale value never looks valid
				count_out <= ~count_in;
				{underrun_out, babble_out, err_out} <= ~flags_in;
			end
		end
	end
endmodule : hims_iso_endpoint

/* File: dv/hims_uframe_status_tb.sv */
// Self-checking bench for the microframe status block
`timescale 1ns/1ps
module hims_uframe_status_tb;
	logic        clk_in = 1'b0, resetn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, usof_in = 1'b0;
	logic        token_in_in = 1'b0, xact_done_in, xact_err_in, xact_babble_in, xact_underrun_in;
	logic        xact_issue_out, irq_out;
	logic [4:0]  reg_addr_in = 5'h00, bus_frame_in = 5'h00;
	logic [31:0] reg_wdata_in = 32'h00000000, reg_rdata_out;
	logic [2:0]  usof_index_in = 3'h0, xact_uframe_out, p_flags = 3'h0;
	logic [11:0] xact_count_in, p_count = 12'h000;
	logic [3:0]  p_delay = 4'h0;
	int          err_count = 0, n_compared = 0, m_mask = 0, m_frame = 0, m_stat = 0, m_imask = 0;
	int          m_cnt [8], m_res [8];
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	hims_uframe_status u_hims_uframe_status (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.usof_in(usof_in), .bus_frame_in(bus_frame_in), .usof_index_in(usof_index_in), .token_in_in(token_in_in),
		.xact_done_in(xact_done_in), .xact_count_in(xact_count_in), .xact_err_in(xact_err_in),
		.xact_babble_in(xact_babble_in), .xact_underrun_in(xact_underrun_in), .xact_issue_out(xact_issue_out),
		.xact_uframe_out(xact_uframe_out), .irq_out(irq_out));
	hims_iso_endpoint u_hims_iso_endpoint (.clk_in(clk_in), .issue_in(xact_issue_out), .delay_in(p_delay),
		.count_in(p_count), .flags_in(p_flags), .done_out(xact_done_in), .count_out(xact_count_in),
		.err_out(xact_err_in), .babble_out(xact_babble_in), .underrun_out(xact_underrun_in));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	function automatic logic [31:0] exp_reg(input logic [4:0] a);
		logic [95:0] cnts;
		logic [23:0] ress;
		for (int i = 0; i < 8; i++) begin
			cnts[i*12 +: 12] = m_cnt[i][11:0];
			ress[i*3 +: 3] = m_res[i][2:0];
		end
		case (a)
			5'h00: exp_reg = {ress, m_mask[7:0]};
			5'h04: exp_reg = cnts[31:0];
			5'h08: exp_reg = cnts[63:32];
			5'h0C: exp_reg = cnts[95:64];
			5'h10: exp_reg = {24'h000000, m_frame[7:0]};
			5'h14: exp_reg = {29'h00000000, m_stat[2:0]};
			5'h18: exp_reg = {29'h00000000, m_imask[2:0]};
			default: exp_reg = 32'h00000000;
		endcase
	endfunction : exp_reg
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		if (a == 5'h00) m_mask = m_mask | int'(d[7:0]);
		if (a == 5'h10) m_frame = int'(d[7:0]);
		if (a == 5'h14) m_stat = m_stat & ~int'(d[2:0]);
		if (a == 5'h18) m_imask = int'(d[2:0]);
	endtask : wr_reg
	task automatic rd_chk(input logic [4:0] a);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		check(reg_rdata_out, exp_reg(a));
		check(32'(irq_out), 32'(|(m_stat & m_imask)));
	endtask : rd_chk
	task automatic uframe(input int i, input logic [4:0] fr, input bit cut = 1'b0);
		int n;
		logic hit;
		@(posedge clk_in);
		hit = (fr == m_frame[7:3]) && m_mask[i];
		p_count <= 12'($urandom);
		p_flags <= 3'($urandom);
		p_delay <= cut ? 4'h5 : 4'($urandom_range(0, 5));
		token_in_in <= 1'($urandom);
		usof_in <= 1'b1;
		bus_frame_in <= fr;
		usof_index_in <= 3'(i);
		@(posedge clk_in);
		usof_in <= 1'b0;
		#1;
		check(32'(xact_issue_out), 32'(hit));
		if (hit && cut) begin
			// New start before the answer abandons the wait, slot and mask untouched
			@(posedge clk_in);
			usof_in <= 1'b1;
			bus_frame_in <= ~fr;
			@(posedge clk_in);
			usof_in <= 1'b0;
			#1;
			check(32'(xact_issue_out), 32'h00000000);
			repeat (8) @(posedge clk_in);
		end else if (hit) begin
			check(32'(xact_uframe_out), i);
			n = 0;
			do begin
				@(posedge clk_in);
				#1;
				n++;
			end while (xact_done_in !== 1'b1 && n < 20);
			if (n >= 20) begin
				err_count++;
				report_and_stop();
			end
			m_cnt[i] = int'(p_count);
			m_res[i] = int'({p_flags[2] & !token_in_in, p_flags[1] & token_in_in, p_flags[0]});
			m_mask = m_mask & ~(1 << i);
			m_stat = m_stat | 1 | (int'(m_res[i] != 0) << 1) | (int'(m_mask == 0) << 2);
			@(posedge clk_in);
		end
	endtask : uframe
	initial begin
		void'($urandom(92));
		repeat (10) @(posedge clk_in);
		resetn_in <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			for (int a = 0; a < 32; a += 2) rd_chk(5'(a));
			wr_reg(5'h10, 32'h0000005D);
			wr_reg(5'h18, 32'hFFFFFFFF);
			wr_reg(5'h04, 32'hFFFFFFFF);
			wr_reg(5'h00, (r == 0) ? 32'hFFFFFF55 : 32'h000000FF);
			wr_reg(5'h00, 32'h00000000);
			uframe(3, 5'h0C);
			uframe(0, 5'h0B, 1'b1);
			rd_chk(5'h00);
			rd_chk(5'h04);
			for (int i = 0; i < 8; i++) uframe(i, 5'h0B);
			for (int a = 0; a < 28; a += 4) rd_chk(5'(a));
			wr_reg(5'h14, 32'h00000007);
			rd_chk(5'h14);
			for (int k = 0; k < 40; k++) begin
				wr_reg(5'h00, $urandom);
				wr_reg(5'h18, $urandom);
				uframe($urandom_range(0, 7), 5'($urandom_range(11, 12)), 1'($urandom));
				rd_chk(5'($urandom_range(0, 7) * 4));
			end
			@(posedge clk_in);
			resetn_in <= 1'b0;
			repeat (10) @(posedge clk_in);
			resetn_in <= 1'b1;
			{m_mask, m_frame, m_stat, m_imask} = '0;
			for (int i = 0; i < 8; i++) {m_cnt[i], m_res[i]} = '0;
		end
		report_and_stop();
	end
endmodule : hims_uframe_status_tb
bind hims_uframe_status hims_uframe_status_sva #(.UFRAMES(UFRAMES), .COUNT_W(COUNT_W)) u_hims_uframe_status_sva (
	.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .usof_in(usof_in),
	.bus_frame_in(bus_frame_in), .usof_index_in(usof_index_in), .token_in_in(token_in_in),
	.xact_done_in(xact_done_in), .xact_count_in(xact_count_in), .xact_err_in(xact_err_in),
	.xact_babble_in(xact_babble_in), .xact_underrun_in(xact_underrun_in), .xact_issue_out(xact_issue_out),
	.xact_uframe_out(xact_uframe_out), .irq_out(irq_out));
